// [hdl/fse_pkg.sv]
// Purpose: Shared constants and types for the NaN and operand-error exception unit.
// Assumes: Registers are 32-bit words on APB at byte offsets that are multiples of four.
// Notes:   Operands are extended precision: sign, 15-bit biased exponent, 64-bit mantissa.
package fse_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_SRC_SE = 8'h08;
  localparam logic [7:0] OFS_SRC_MH = 8'h0c;
  localparam logic [7:0] OFS_SRC_ML = 8'h10;
  localparam logic [7:0] OFS_DST_SE = 8'h14;
  localparam logic [7:0] OFS_DST_MH = 8'h18;
  localparam logic [7:0] OFS_DST_ML = 8'h1c;
  localparam logic [7:0] OFS_IADDR  = 8'h20;
  localparam logic [7:0] OFS_EA     = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_REPORT = 8'h2c;
  localparam logic [7:0] OFS_RES_SE = 8'h30;
  localparam logic [7:0] OFS_RES_MH = 8'h34;
  localparam logic [7:0] OFS_RES_ML = 8'h38;
  localparam logic [7:0] OFS_FRM    = 8'h3c;
  localparam logic [7:0] OFS_STM_SE = 8'h40;
  localparam logic [7:0] OFS_STM_MH = 8'h44;
  localparam logic [7:0] OFS_STM_ML = 8'h48;
  localparam logic [7:0] OFS_DTM_SE = 8'h4c;
  localparam logic [7:0] OFS_DTM_MH = 8'h50;
  localparam logic [7:0] OFS_DTM_ML = 8'h54;
  localparam logic [7:0] OFS_WRITEBACK_TEMP_FIELD = 8'h58;
  localparam logic [7:0] OFS_FIAR   = 8'h5c;
  localparam logic [7:0] OFS_FEA    = 8'h60;

  // Field positions.
  localparam int CTRL_SIGNALING_NAN_EN  = 0;
  localparam int CTRL_INVALID_OPERAND_FLAG_EN = 1;
  localparam int ST_SIGNALING_NAN       = 14;
  localparam int ST_INVALID_OPERAND_FLAG      = 13;
  localparam int CMD_OP_LSB    = 16;
  localparam int CMD_FMT_LSB   = 20;
  localparam int CMD_KIND_LSB  = 24;

  // Reset values and special encodings.
  localparam logic [1:0]  CTRL_RST   = 2'h0;
  localparam logic [14:0] EXP_MAX    = 15'h7fff;
  localparam logic [14:0] EXP_BIAS   = 15'h3fff;
  localparam logic [63:0] MANT_ONES  = 64'hffffffffffffffff;
  localparam int          QUIET_BIT  = 62;

  typedef enum logic [2:0] {
    OP_ADD   = 3'b000,
    OP_SUB   = 3'b001,
    OP_MUL   = 3'b010,
    OP_DIV   = 3'b011,
    OP_SQRT  = 3'b100,
    OP_MOVE  = 3'b101,
    OP_MMOVE = 3'b110,
    OP_CTRL  = 3'b111
  } fse_op_t;

  typedef enum logic [2:0] {
    FMT_L = 3'b000,
    FMT_S = 3'b001,
    FMT_X = 3'b010,
    FMT_P = 3'b011,
    FMT_W = 3'b100,
    FMT_D = 3'b101,
    FMT_B = 3'b110,
    FMT_R = 3'b111
  } fse_fmt_t;

  typedef enum logic [1:0] {
    KIND_FPREG = 2'b00,
    KIND_MEM   = 2'b01,
    KIND_IREG  = 2'b10,
    KIND_RSVD  = 2'b11
  } fse_kind_t;

  typedef enum logic [2:0] {
    TAG_NORM = 3'b000,
    TAG_ZERO = 3'b001,
    TAG_INF  = 3'b010,
    TAG_NAN  = 3'b011,
    TAG_DEN  = 3'b100
  } fse_tag_t;

  typedef struct packed {
    logic        sign;
    logic [14:0] exp;
    logic [63:0] mant;
  } fse_ext_t;

  typedef struct packed {
    logic [1:0]  ctrl;
    logic [31:0] cmd;
    fse_ext_t    src;
    fse_ext_t    dst;
    logic [31:0] iaddr;
    logic [31:0] ea;
    logic        go;
    logic        st_signaling_nan;
    logic        st_invalid_operand_flag;
    fse_ext_t    res;
    logic        done;
    logic        rep_pre;
    logic        rep_post;
    logic        rep_fpwe;
    logic        rep_store;
    logic [15:0] f_cmdw;
    fse_ext_t    f_stemp;
    fse_tag_t    f_source_tag;
    fse_ext_t    f_dtemp;
    fse_tag_t    f_dest_tag;
    logic        f_tflag;
    logic [31:0] f_wb;
    logic [31:0] f_iar;
    logic [31:0] f_ea;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        exc_pre;
    logic        exc_post;
    logic        fpreg_we;
  } fse_state_t;

endpackage

// [hdl/fse_unit.sv]
// Purpose: Signaling-NaN and operand-error detection, default results and exception reporting.
// Assumes: One 250 MHz clock, synchronous active-low reset, APB slave with one wait-free access phase.
// Notes:   Writing the command register starts one evaluation of the stored operands.
`timescale 1ns/1ps

module fse_unit
(
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             EXC_PRE,
  output logic             EXC_POST,
  output logic             FPREG_WE
);

  fse_pkg::fse_state_t s_q;
  fse_pkg::fse_state_t s_d;

  // Operand classification.
  // The explicit integer bit is ignored, so unnormal infinities and NaNs classify by fraction alone.
  function automatic logic is_nan(input fse_pkg::fse_ext_t v);
    is_nan = (v.exp == fse_pkg::EXP_MAX) && (|v.mant[62:0]);
  endfunction

  function automatic logic is_inf(input fse_pkg::fse_ext_t v);
    is_inf = (v.exp == fse_pkg::EXP_MAX) && !(|v.mant[62:0]);
  endfunction

  function automatic logic is_zero(input fse_pkg::fse_ext_t v);
    is_zero = (v.exp == 15'h0000) && (v.mant == 64'h0000000000000000);
  endfunction

  // Zero is tested before denormal, since both carry a zero exponent.
  function automatic fse_pkg::fse_tag_t tag_of(input fse_pkg::fse_ext_t v);
    if (is_nan(v))
      tag_of = fse_pkg::TAG_NAN;
    else if (is_inf(v))
      tag_of = fse_pkg::TAG_INF;
    else if (is_zero(v))
      tag_of = fse_pkg::TAG_ZERO;
    else if (v.exp == 15'h0000)
      tag_of = fse_pkg::TAG_DEN;
    else
      tag_of = fse_pkg::TAG_NORM;
  endfunction

  // Only NaNs are touched, so ordinary operands pass through unchanged.
  function automatic fse_pkg::fse_ext_t quieten(input fse_pkg::fse_ext_t v);
    fse_pkg::fse_ext_t r;
    r = v;
    if (is_nan(v))
      r.mant[fse_pkg::QUIET_BIT] = 1'b1;
    quieten = r;
  endfunction

  function automatic logic [31:0] se_word(input fse_pkg::fse_ext_t v);
    se_word = {16'h0000, v.sign, v.exp};
  endfunction

  // Command decode.
  // Reserved destination kind 3 is not refused; it behaves as a memory destination.
  fse_pkg::fse_op_t   op;
  fse_pkg::fse_fmt_t  fmt;
  fse_pkg::fse_kind_t kind;
  assign op   = fse_pkg::fse_op_t'(s_q.cmd[fse_pkg::CMD_OP_LSB +: 3]);
  assign fmt  = fse_pkg::fse_fmt_t'(s_q.cmd[fse_pkg::CMD_FMT_LSB +: 3]);
  assign kind = fse_pkg::fse_kind_t'(s_q.cmd[fse_pkg::CMD_KIND_LSB +: 2]);

  logic src_nan;
  logic src_signaling_nan;
  logic src_inf;
  logic src_zero;
  logic dst_signaling_nan;
  logic dst_inf;
  logic dst_zero;
  assign src_nan  = is_nan(s_q.src);
  assign src_signaling_nan = src_nan && !s_q.src.mant[fse_pkg::QUIET_BIT];
  assign src_inf  = is_inf(s_q.src);
  assign src_zero = is_zero(s_q.src);
  assign dst_signaling_nan = is_nan(s_q.dst) && !s_q.dst.mant[fse_pkg::QUIET_BIT];
  assign dst_inf  = is_inf(s_q.dst);
  assign dst_zero = is_zero(s_q.dst);

  // Control moves and state saves have separate codes, 6 and 7; neither may touch status or trap.
  logic is_arith;
  logic is_dyadic;
  logic int_fmt;
  logic to_int;
  logic to_fpreg;
  assign is_arith  = (op != fse_pkg::OP_MMOVE) && (op != fse_pkg::OP_CTRL);
  assign is_dyadic = (op == fse_pkg::OP_ADD) || (op == fse_pkg::OP_SUB) ||
                     (op == fse_pkg::OP_MUL) || (op == fse_pkg::OP_DIV);
  assign int_fmt   = (fmt == fse_pkg::FMT_B) || (fmt == fse_pkg::FMT_W) || (fmt == fse_pkg::FMT_L);
  assign to_fpreg  = (kind == fse_pkg::KIND_FPREG);
  assign to_int    = (op == fse_pkg::OP_MOVE) && !to_fpreg && int_fmt;

  // Integer conversion; truncation stands in for rounding here.
  // Only the top 32 mantissa bits reach the converter, which is enough for L and narrower.
  // A limitation: no rounding mode is applied, so a value just below a limit never trips.
  // The writeback word is therefore exact only for values that are already integers.
  logic [15:0] int_bits;
  logic [15:0] unb_exp;
  logic        int_big;
  logic [4:0]  int_shift;
  logic [31:0] int_mag;
  logic [31:0] int_val;
  always_comb
  begin
    unique case (fmt)
      fse_pkg::FMT_B: int_bits = 16'h0008;
      fse_pkg::FMT_W: int_bits = 16'h0010;
      default:        int_bits = 16'h0020;
    endcase
  end
  assign unb_exp   = {1'b0, s_q.src.exp} - {1'b0, fse_pkg::EXP_BIAS};
  // Magnitudes at or past two to the width minus one trip, so the most negative value does too.
  assign int_big   = (s_q.src.exp >= fse_pkg::EXP_BIAS) && (unb_exp >= int_bits - 16'h0001);
  assign int_shift = 5'h1f - unb_exp[4:0];
  assign int_mag   = (s_q.src.exp < fse_pkg::EXP_BIAS) ? 32'h00000000 :
                     (unb_exp > 16'h001f) ? s_q.src.mant[63:32] : (s_q.src.mant[63:32] >> int_shift);
  assign int_val   = s_q.src.sign ? (32'h00000000 - int_mag) : int_mag;

  // Exception detection.
  // Status flags follow detection alone; the trap enables never gate them.
  logic signaling_nan_hit;
  logic invalid_operand_flag_hit;
  logic take_pre;
  logic take_post;
  assign signaling_nan_hit = is_arith && (src_signaling_nan || (is_dyadic && dst_signaling_nan));
  always_comb
  begin
    invalid_operand_flag_hit = 1'b0;
    unique case (op)
      fse_pkg::OP_ADD:  invalid_operand_flag_hit = src_inf && dst_inf && (s_q.src.sign != s_q.dst.sign);
      fse_pkg::OP_SUB:  invalid_operand_flag_hit = src_inf && dst_inf && (s_q.src.sign == s_q.dst.sign);
      fse_pkg::OP_MUL:  invalid_operand_flag_hit = (src_zero && dst_inf) || (src_inf && dst_zero);
      fse_pkg::OP_DIV:  invalid_operand_flag_hit = (src_zero && dst_zero) || (src_inf && dst_inf);
      fse_pkg::OP_SQRT: invalid_operand_flag_hit = s_q.src.sign && !src_zero && !src_nan;
      // A signaling NaN is its own exception; its maximal exponent must not read as overflow.
      fse_pkg::OP_MOVE: invalid_operand_flag_hit = to_int && !src_signaling_nan && (src_nan || src_inf || int_big);
      fse_pkg::OP_MMOVE: invalid_operand_flag_hit = 1'b0;
      fse_pkg::OP_CTRL:  invalid_operand_flag_hit = 1'b0;
    endcase
  end

  // Each trap enable only governs its own exception.
  // Integer destinations post whatever the enable says, since the undefined store has already happened.
  assign take_pre  = to_fpreg && ((signaling_nan_hit && s_q.ctrl[fse_pkg::CTRL_SIGNALING_NAN_EN]) ||
                     (invalid_operand_flag_hit && s_q.ctrl[fse_pkg::CTRL_INVALID_OPERAND_FLAG_EN]));
  assign take_post = !to_fpreg && ((int_fmt && (signaling_nan_hit || invalid_operand_flag_hit)) ||
                     (signaling_nan_hit && s_q.ctrl[fse_pkg::CTRL_SIGNALING_NAN_EN]));

  // Default result.
  // An undefined integer store is all zeros, which keeps the handler's rewrite deterministic.
  // Single and double truncation clears the mantissa bits below each format's width.
  // A dyadic operation quietens whichever operand is the signaling NaN, source first.
  // Plain arithmetic to a register destination writes nothing here; the result datapath lives elsewhere.
  fse_pkg::fse_ext_t nan_in;
  fse_pkg::fse_ext_t res_val;
  logic              res_write;
  assign nan_in = src_signaling_nan ? s_q.src : s_q.dst;
  always_comb
  begin
    res_val = s_q.src;
    if (signaling_nan_hit && !int_fmt)
    begin
      res_val = quieten(nan_in);
      if (fmt == fse_pkg::FMT_S)
        res_val.mant[39:0] = 40'h0000000000;
      else if (fmt == fse_pkg::FMT_D)
        res_val.mant[10:0] = 11'h000;
    end
    else if (int_fmt && !to_fpreg && (signaling_nan_hit || invalid_operand_flag_hit))
      res_val = '0;
    else if (invalid_operand_flag_hit)
      res_val = '{sign: 1'b0, exp: fse_pkg::EXP_MAX, mant: fse_pkg::MANT_ONES};
    else if (op != fse_pkg::OP_MMOVE)
      res_val = quieten(s_q.src);
  end
  assign res_write = !take_pre && (op != fse_pkg::OP_CTRL) &&
                     (!to_fpreg || signaling_nan_hit || invalid_operand_flag_hit ||
                      (op == fse_pkg::OP_MOVE) || (op == fse_pkg::OP_MMOVE));

  // Register read mux.
  // Reads have no side effects; the sticky flags clear only by writing ones.
  logic [31:0] rd_data;
  logic        rd_hit;
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_data = 32'h00000000;
    unique case (PADDR)
      fse_pkg::OFS_CTRL:   rd_data = {30'h00000000, s_q.ctrl};
      fse_pkg::OFS_CMD:    rd_data = s_q.cmd;
      fse_pkg::OFS_SRC_SE: rd_data = se_word(s_q.src);
      fse_pkg::OFS_SRC_MH: rd_data = s_q.src.mant[63:32];
      fse_pkg::OFS_SRC_ML: rd_data = s_q.src.mant[31:0];
      fse_pkg::OFS_DST_SE: rd_data = se_word(s_q.dst);
      fse_pkg::OFS_DST_MH: rd_data = s_q.dst.mant[63:32];
      fse_pkg::OFS_DST_ML: rd_data = s_q.dst.mant[31:0];
      fse_pkg::OFS_IADDR:  rd_data = s_q.iaddr;
      fse_pkg::OFS_EA:     rd_data = s_q.ea;
      fse_pkg::OFS_STATUS:
      begin
        rd_data[fse_pkg::ST_SIGNALING_NAN]  = s_q.st_signaling_nan;
        rd_data[fse_pkg::ST_INVALID_OPERAND_FLAG] = s_q.st_invalid_operand_flag;
      end
      fse_pkg::OFS_REPORT:
        rd_data = {26'h0000000, s_q.go, s_q.rep_store, s_q.rep_fpwe, s_q.rep_post, s_q.rep_pre, s_q.done};
      fse_pkg::OFS_RES_SE: rd_data = se_word(s_q.res);
      fse_pkg::OFS_RES_MH: rd_data = s_q.res.mant[63:32];
      fse_pkg::OFS_RES_ML: rd_data = s_q.res.mant[31:0];
      fse_pkg::OFS_FRM:
        rd_data = {8'h00, s_q.f_tflag, s_q.f_dest_tag, 1'b0, s_q.f_source_tag, s_q.f_cmdw};
      fse_pkg::OFS_STM_SE: rd_data = se_word(s_q.f_stemp);
      fse_pkg::OFS_STM_MH: rd_data = s_q.f_stemp.mant[63:32];
      fse_pkg::OFS_STM_ML: rd_data = s_q.f_stemp.mant[31:0];
      fse_pkg::OFS_DTM_SE: rd_data = se_word(s_q.f_dtemp);
      fse_pkg::OFS_DTM_MH: rd_data = s_q.f_dtemp.mant[63:32];
      fse_pkg::OFS_DTM_ML: rd_data = s_q.f_dtemp.mant[31:0];
      fse_pkg::OFS_WRITEBACK_TEMP_FIELD: rd_data = s_q.f_wb;
      fse_pkg::OFS_FIAR:   rd_data = s_q.f_iar;
      fse_pkg::OFS_FEA:    rd_data = s_q.f_ea;
      default:             rd_hit  = 1'b0;
    endcase
  end

  // A write lands only at the access edge, while the answer prepared in setup stands.
  logic wr_acc;
  assign wr_acc = PSEL && PENABLE && PWRITE && s_q.pready;

  always_comb
  begin
    // Pulses default low each cycle so every outcome stands for exactly one clock.
    s_d          = s_q;
    s_d.go       = 1'b0;
    s_d.pready   = 1'b0;
    s_d.pslverr  = 1'b0;
    s_d.exc_pre  = 1'b0;
    s_d.exc_post = 1'b0;
    s_d.fpreg_we = 1'b0;
    // Answer is prepared in the setup cycle so the access phase never waits.
    if (PSEL && !PENABLE)
    begin
      s_d.pready  = 1'b1;
      s_d.prdata  = PWRITE ? 32'h00000000 : rd_data;
      s_d.pslverr = !rd_hit;
    end
    if (wr_acc)
    begin
      unique case (PADDR)
        fse_pkg::OFS_CTRL:   s_d.ctrl = PWDATA[1:0];
        fse_pkg::OFS_CMD:
        begin
          s_d.cmd  = PWDATA;
          s_d.go   = 1'b1;
          s_d.done = 1'b0;
        end
        fse_pkg::OFS_SRC_SE: {s_d.src.sign, s_d.src.exp} = PWDATA[15:0];
        fse_pkg::OFS_SRC_MH: s_d.src.mant[63:32] = PWDATA;
        fse_pkg::OFS_SRC_ML: s_d.src.mant[31:0] = PWDATA;
        fse_pkg::OFS_DST_SE: {s_d.dst.sign, s_d.dst.exp} = PWDATA[15:0];
        fse_pkg::OFS_DST_MH: s_d.dst.mant[63:32] = PWDATA;
        fse_pkg::OFS_DST_ML: s_d.dst.mant[31:0] = PWDATA;
        fse_pkg::OFS_IADDR:  s_d.iaddr = PWDATA;
        fse_pkg::OFS_EA:     s_d.ea = PWDATA;
        fse_pkg::OFS_STATUS:
        begin
          // A zero leaves its flag alone, so one flag clears without losing the other.
          if (PWDATA[fse_pkg::ST_SIGNALING_NAN])
            s_d.st_signaling_nan = 1'b0;
          if (PWDATA[fse_pkg::ST_INVALID_OPERAND_FLAG])
            s_d.st_invalid_operand_flag = 1'b0;
        end
        default: ;
      endcase
    end
    // Evaluation comes after the clear so a flag raised in the same cycle survives.
    if (s_q.go)
    begin
      s_d.done      = 1'b1;
      s_d.st_signaling_nan   = s_d.st_signaling_nan || signaling_nan_hit;
      s_d.st_invalid_operand_flag  = s_d.st_invalid_operand_flag || invalid_operand_flag_hit;
      s_d.rep_pre   = take_pre;
      s_d.rep_post  = take_post;
      s_d.exc_pre   = take_pre;
      s_d.exc_post  = take_post;
      s_d.rep_fpwe  = res_write && to_fpreg;
      s_d.fpreg_we  = res_write && to_fpreg;
      s_d.rep_store = res_write && !to_fpreg;
      if (res_write)
        s_d.res = res_val;
      // The frame is rewritten only on an exception, so software sees the last trapped instruction.
      // Fields a frame kind does not define are cleared so nothing stale from an older trap survives.
      if (take_pre)
      begin
        s_d.f_cmdw  = s_q.cmd[15:0];
        s_d.f_stemp = quieten(s_q.src);
        s_d.f_source_tag  = tag_of(s_q.src);
        s_d.f_dtemp = is_dyadic ? quieten(s_q.dst) : '0;
        s_d.f_dest_tag  = is_dyadic ? tag_of(s_q.dst) : fse_pkg::TAG_NORM;
        s_d.f_tflag = 1'b0;
        s_d.f_iar   = s_q.iaddr;
        s_d.f_wb    = 32'h00000000;
        s_d.f_ea    = 32'h00000000;
      end
      else if (take_post)
      begin
        // Post frames carry no destination operand; the writeback holds the truncated integer.
        s_d.f_cmdw  = s_q.cmd[15:0];
        s_d.f_stemp = signaling_nan_hit ? quieten(s_q.src) : s_q.src;
        s_d.f_source_tag  = tag_of(s_q.src);
        s_d.f_dtemp = '0;
        s_d.f_dest_tag  = fse_pkg::TAG_NORM;
        s_d.f_tflag = 1'b1;
        s_d.f_wb    = int_val;
        s_d.f_iar   = s_q.iaddr;
        s_d.f_ea    = s_q.ea;
      end
    end
  end

  // Trap enables restart disabled, so after reset only an integer store with an exception can trap.
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      s_q      <= '0;
      s_q.ctrl <= fse_pkg::CTRL_RST;
    end
    else
      s_q <= s_d;
  end

  // All outputs come straight from the state register, so none glitches between edges.
  assign PRDATA   = s_q.prdata;
  assign PREADY   = s_q.pready;
  assign PSLVERR  = s_q.pslverr;
  assign EXC_PRE  = s_q.exc_pre;
  assign EXC_POST = s_q.exc_post;
  assign FPREG_WE = s_q.fpreg_we;

endmodule

// [dv/fse_unit_properties.sv]
// Purpose: Port-level properties of the NaN and operand-error exception unit.
// Assumes: One clock domain; reset is synchronous and active low.
// Notes:   Outcome pulses are tied back to the command write two edges earlier.
`timescale 1ns/1ps
module fse_unit_checker
(
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        EXC_PRE,
  input wire logic        EXC_POST,
  input wire logic        FPREG_WE
);
  logic setup;
  logic cmd_wr;
  assign setup  = PSEL && !PENABLE;
  assign cmd_wr = PSEL && PENABLE && PREADY && PWRITE && (PADDR == fse_pkg::OFS_CMD);

  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  sequence s_quiet_cmd;
    cmd_wr && (PWDATA[18:16] >= 3'h6);
  endsequence
  sequence s_mem_cmd;
    cmd_wr && (PWDATA[25:24] != 2'h0);
  endsequence
  sequence s_reg_cmd;
    cmd_wr && (PWDATA[25:24] == 2'h0);
  endsequence

  ready_after_setup_a: assert property (setup |=> PREADY)
    else $error("PREADY missing after setup");
  ready_cause_a: assert property (PREADY |-> $past(setup))
    else $error("PREADY without setup");
  error_with_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("PSLVERR outside access");
  outcome_timing_a: assert property ((EXC_PRE || EXC_POST || FPREG_WE) |-> $past(cmd_wr, 2))
    else $error("Outcome pulse without command");
  quiet_ops_a: assert property (s_quiet_cmd |-> ##2 (!EXC_PRE && !EXC_POST))
    else $error("Exception from a quiet move");
  mem_no_pre_a: assert property (s_mem_cmd |-> ##2 (!EXC_PRE && !FPREG_WE))
    else $error("Register outcome for memory destination");
  reg_no_post_a: assert property (s_reg_cmd |-> ##2 !EXC_POST)
    else $error("Post exception for register destination");
  pre_blocks_write_a: assert property (EXC_PRE |-> !FPREG_WE && !EXC_POST)
    else $error("Register written with pre exception");
  post_single_a: assert property (EXC_POST |=> !EXC_POST)
    else $error("Post exception longer than one cycle");
endmodule

bind fse_unit fse_unit_checker u_chk (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EXC_PRE(EXC_PRE),
  .EXC_POST(EXC_POST), .FPREG_WE(FPREG_WE));

// [dv/fse_int_model.sv]
// Purpose: Integer-unit stand-in that takes the exception and register-write pulses.
// Assumes: Each pulse lasts one clock and is counted at the edge that samples it.
// Notes:   Handler stores are not modelled; the bench judges the frame registers instead.
`timescale 1ns/1ps
module fse_int_model
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic exc_pre,
  input  wire logic exc_post,
  input  wire logic fpreg_we,
  output int        n_pre,
  output int        n_post,
  output int        n_we
);
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      n_pre  <= 0;
      n_post <= 0;
      n_we   <= 0;
    end
    else
    begin
      n_pre  <= n_pre + int'(exc_pre);
      n_post <= n_post + int'(exc_post);
      n_we   <= n_we + int'(fpreg_we);
    end
  end
endmodule

// [dv/fse_unit_tb_top.sv]
// Purpose: Self-checking bench for the NaN and operand-error exception unit.
// Assumes: Results are readable two edges after the command write ends.
// Notes:   Command codes are three hex digits: destination kind, format, operation.
`timescale 1ns/1ps
module fse_unit_tb_top;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        exc_pre;
  logic        exc_post;
  logic        fpreg_we;
  int          n_pre;
  int          n_post;
  int          n_we;
  int          failures;
  int          cmp_count;
  logic [31:0] rd;
  logic        err;
  localparam logic [15:0] CW   = 16'h4a21;
  localparam logic [79:0] SIGNALING_NAN = 80'h7fff_8000000000000001;
  localparam logic [79:0] PINF = 80'h7fff_8000000000000000;
  localparam logic [79:0] NINF = 80'hffff_8000000000000000;
  localparam logic [79:0] ONE  = 80'h3fff_8000000000000000;

  fse_unit u_dut (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXC_PRE(exc_pre),
    .EXC_POST(exc_post), .FPREG_WE(fpreg_we));
  fse_int_model u_iu (.clk(clk), .rst_b(rst_b), .exc_pre(exc_pre), .exc_post(exc_post), .fpreg_we(fpreg_we),
    .n_pre(n_pre), .n_post(n_post), .n_we(n_we));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_sim();
    if (failures == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  // Loads both operands, instruction and destination addresses, then issues one command.
  task automatic run_op(input logic [1:0] ctrl, input logic [11:0] code, input logic [79:0] s,
                        input logic [79:0] d, input logic [2:0] evt, input logic [1:0] st);
    logic [255:0] v;
    int           p0;
    int           q0;
    int           w0;
    v = {16'h0, s, 16'h0, d, 32'h00001000, 32'h00002000};
    apb(1'b1, fse_pkg::OFS_CTRL, {30'h0, ctrl});
    for (int i = 0; i < 8; i++)
      apb(1'b1, fse_pkg::OFS_SRC_SE + 8'(4 * i), v[255 - 32 * i -: 32]);
    p0 = n_pre;
    q0 = n_post;
    w0 = n_we;
    apb(1'b1, fse_pkg::OFS_CMD, {6'h0, code[9:8], 1'b0, code[6:4], 1'b0, code[2:0], CW});
    repeat (2) @(posedge clk);
    rdchk("status", fse_pkg::OFS_STATUS, {17'h0, st, 13'h0});
    chk("events", {8'h0, 8'(evt[2]), 8'(evt[1]), 8'(evt[0])}, {8'h0, 8'(n_pre - p0), 8'(n_post - q0), 8'(n_we - w0)});
    apb(1'b1, fse_pkg::OFS_STATUS, 32'h00006000);
  endtask

  task automatic t_reset_map();
    rdchk("ctrl", fse_pkg::OFS_CTRL, 32'h0);
    rdchk("status", fse_pkg::OFS_STATUS, 32'h0);
    rdchk("unmapped", 8'hfc, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
  endtask

  task automatic t_signaling_nan_reg();
    run_op(2'h0, 12'h020, SIGNALING_NAN, ONE, 3'b001, 2'b10);
    rdchk("res_mh", fse_pkg::OFS_RES_MH, 32'hc0000000);
    rdchk("res_ml", fse_pkg::OFS_RES_ML, 32'h00000001);
    run_op(2'h0, 12'h025, SIGNALING_NAN, 80'h0, 3'b001, 2'b10);
    rdchk("res_mh", fse_pkg::OFS_RES_MH, 32'hc0000000);
    run_op(2'h1, 12'h020, SIGNALING_NAN, ONE, 3'b100, 2'b10);
    rdchk("frame", fse_pkg::OFS_FRM, {16'h0003, CW});
    rdchk("stemp", fse_pkg::OFS_STM_MH, 32'hc0000000);
    rdchk("dtemp", fse_pkg::OFS_DTM_SE, 32'h00003fff);
    run_op(2'h2, 12'h020, SIGNALING_NAN, ONE, 3'b001, 2'b10);
  endtask

  task automatic t_signaling_nan_store();
    logic [3:0]  f [3] = '{4'h6, 4'h4, 4'h0};
    logic [31:0] h [3] = '{32'h000000c0, 32'h0000c000, 32'hc0000000};
    for (int i = 0; i < 6; i++)
    begin
      run_op(2'(i % 2), {4'h1, f[i / 2], 4'h5}, SIGNALING_NAN, 80'h0, 3'b010, 2'b10);
      rdchk("frame", fse_pkg::OFS_FRM, {16'h0083, CW});
      rdchk("stemp", fse_pkg::OFS_STM_MH, 32'hc0000000);
      chk("handler", h[i / 2], rd >> (32 - 8 * (1 << (i / 2))));
    end
    run_op(2'h1, 12'h215, SIGNALING_NAN, 80'h0, 3'b010, 2'b10);
    run_op(2'h0, 12'h215, SIGNALING_NAN, 80'h0, 3'b000, 2'b10);
    rdchk("res_ml", fse_pkg::OFS_RES_ML, 32'h00000000);
  endtask

  task automatic t_quiet_ops();
    run_op(2'h3, 12'h026, SIGNALING_NAN, ONE, 3'b001, 2'b00);
    rdchk("res_mh", fse_pkg::OFS_RES_MH, 32'h80000000);
    run_op(2'h3, 12'h127, SIGNALING_NAN, ONE, 3'b000, 2'b00);
  endtask

  task automatic t_invalid_operand_flag_reg();
    logic [3:0]  op [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h3, 4'h4, 4'h4};
    logic [79:0] s  [7] = '{PINF, PINF, 80'h0, 80'h0, PINF, 80'hbfff_8000000000000000, NINF};
    logic [79:0] d  [7] = '{NINF, PINF, PINF, 80'h0, PINF, 80'h0, 80'h0};
    foreach (op[i])
    begin
      run_op(2'h1, {8'h02, op[i]}, s[i], d[i], 3'b001, 2'b01);
      rdchk("res_mh", fse_pkg::OFS_RES_MH, 32'hffffffff);
      rdchk("res_ml", fse_pkg::OFS_RES_ML, 32'hffffffff);
    end
    run_op(2'h2, 12'h002, PINF, 80'h0, 3'b100, 2'b01);
    rdchk("frame", fse_pkg::OFS_FRM, {16'h0012, CW});
  endtask

  task automatic t_int_store();
    logic [79:0] s [3] = '{PINF, 80'h7fff_c000000000000000, 80'h4027_8000000000000000};
    logic [3:0]  f [3] = '{4'h6, 4'h4, 4'h0};
    foreach (s[i])
      foreach (f[j])
        run_op(2'(i), {4'h1, f[j], 4'h5}, s[i], 80'h0, 3'b010, 2'b01);
    run_op(2'h0, 12'h245, 80'hc00e_8000000000000000, 80'h0, 3'b010, 2'b01);
    rdchk("frame", fse_pkg::OFS_FRM, {16'h0080, CW});
    rdchk("iar", fse_pkg::OFS_FIAR, 32'h00001000);
    rdchk("ea", fse_pkg::OFS_FEA, 32'h00002000);
    rdchk("wb", fse_pkg::OFS_WRITEBACK_TEMP_FIELD, 32'hffff8000);
    run_op(2'h0, 12'h245, 80'h400d_8000000000000000, 80'h0, 3'b000, 2'b00);
    run_op(2'h0, 12'h165, NINF, 80'h0, 3'b010, 2'b01);
    rdchk("stemp", fse_pkg::OFS_STM_SE, 32'h0000ffff);
    chk("handler", 32'h00000080, {24'h0, rd[15] ? 8'h80 : 8'h7f});
  endtask

  // A hung handshake must still reach the verdict.
  initial
  begin
    #60us;
    failures++;
    end_sim();
  end

  initial
  begin
    rst_b     = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    failures  = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset_map();
    t_signaling_nan_reg();
    t_signaling_nan_store();
    t_quiet_ops();
    t_invalid_operand_flag_reg();
    t_int_store();
    end_sim();
  end
endmodule
